// file: rtl/tcsi_defines.vh
// Register map, field positions and reset values of the capture timer
`ifndef TCSI_DEFINES_VH
`define TCSI_DEFINES_VH
`define TCSI_OFF_STATUS 12'h000
`define TCSI_OFF_IRQ_EN 12'h004
`define TCSI_OFF_MODE 12'h008
`define TCSI_OFF_PRIO 12'h00c
`define TCSI_OFF_CAP_A 12'h010
`define TCSI_OFF_BUF_C 12'h014
`define TCSI_OFF_IO_CTRL0 12'h018
`define TCSI_OFF_IO_CTRL1 12'h01c
`define TCSI_OFF_COUNTER 12'h020
`define TCSI_BIT_CAP_FLAG 0
`define TCSI_BIT_WRAP_FLAG 7
`define TCSI_BIT_CAP_IRQ_EN 0
`define TCSI_BIT_WRAP_IRQ_EN 7
`define TCSI_BIT_COUNT_RUN 7
`define TCSI_BIT_IRQ_PENDING 3
`define TCSI_BIT_CAP_MODE 2
`define TCSI_BIT_CAP_SEL 3
`define TCSI_BIT_C_FUNC 3
`define TCSI_RST_BYTE 8'h00
`define TCSI_RST_WORD 16'h0000
`define TCSI_EDGE_RISING 2'h0
`define TCSI_DIV_LOG2 7
`endif

// file: rtl/tcsi_div128.v
// Divide-by-128 of the slow oscillator level, sampled in the timer clock domain
`timescale 1ns/1ps
`include "tcsi_defines.vh"
module tcsi_div128 #(
	parameter DIV_LOG2 = `TCSI_DIV_LOG2
) (
	input wire pclk,
	input wire presetn,
	input wire slow_internal_osc,
	output wire slow_osc_div128
);
	reg sync1_reg;
	reg sync2_reg;
	reg prev_reg;
	reg [DIV_LOG2-1:0] div_reg;
	// Oscillator is asynchronous to pclk, so it is synchronised before edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg <= 1'b0;
			div_reg <= {DIV_LOG2{1'b0}};
		end else begin
			sync1_reg <= slow_internal_osc;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
			if (sync2_reg && !prev_reg) begin
				div_reg <= div_reg + {{(DIV_LOG2-1){1'b0}}, 1'b1};
			end
		end
	end
	assign slow_osc_div128 = div_reg[DIV_LOG2-1];
endmodule

// file: rtl/tcsi_timer.v
// Capture timer: counter, capture/buffer registers, flags, interrupts and APB slave
//
// Functional notes
// - Capture and wrap flags clear only on a write of 0 to a bit that was read as 1.
// - A wrap of the counter past its maximum sets the wrap flag in status bit 7.
// - With capture interrupt enable bit 0 set, a set capture flag requests an interrupt.
// - With wrap interrupt enable bit 7 set, a set wrap flag requests an interrupt.
// - Writing 1 to mode bit 7 starts the counter counting its source.
// - Priority control bits 2 to 0 hold the level, and 001 means level 1 with interrupt enabled.
// - Priority control bit 3 is read-only and reads 1 while a timer interrupt is requested.
// - Each capture event latches the counter into capture register A.
// - Register C is a 16-bit buffer holding the value moved to it from register A.
// - The counter increments each source clock from 0000h to FFFFh and flags overflow.
// - With edge bits 1:0 at 00 and mode bit 2 at 1, capture happens on the rising edge.
// - With function select bit 3 of I/O control 1 set, register C buffers register A.
//
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "tcsi_defines.vh"
module tcsi_timer (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	input wire slow_internal_osc,
	input wire capture_pin,
	output wire irq,
	output wire capture_irq_a,
	output wire wrap_irq
);
	reg [15:0] timer_counter_reg;
	reg [15:0] capture_value_a_reg;
	reg [15:0] capture_buffer_c_reg;
	reg capture_flag_a_reg;
	reg counter_wrap_flag_reg;
	reg cap_seen_reg;
	reg wrap_seen_reg;
	reg capture_irq_en_a_reg;
	reg wrap_irq_en_reg;
	reg count_run_reg;
	reg [2:0] irq_level_reg;
	reg [3:0] io_ctrl0_reg;
	reg [3:0] io_ctrl1_reg;
	reg pin_sync1_reg;
	reg pin_sync2_reg;
	reg cap_in_prev_reg;
	wire slow_osc_div128;
	wire cap_in;
	wire cap_event;
	wire wrap_event;
	wire apb_wr;
	wire apb_rd;
	wire hit_valid;
	wire irq_request_pending;
	wire [15:0] wdata16;
	wire wr_cnt;
	wire wr_status;
	wire rd_status;
	reg [31:0] rdata_next;

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `TCSI_OFF_STATUS) || (a == `TCSI_OFF_IRQ_EN) ||
				(a == `TCSI_OFF_MODE) || (a == `TCSI_OFF_PRIO) ||
				(a == `TCSI_OFF_CAP_A) || (a == `TCSI_OFF_BUF_C) ||
				(a == `TCSI_OFF_IO_CTRL0) || (a == `TCSI_OFF_IO_CTRL1) ||
				(a == `TCSI_OFF_COUNTER);
		end
	endfunction

	function [15:0] merge16;
		input [15:0] old;
		input [15:0] wd;
		input [1:0] st;
		begin
			merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	tcsi_div128 u_div (
		.pclk(pclk),
		.presetn(presetn),
		.slow_internal_osc(slow_internal_osc),
		.slow_osc_div128(slow_osc_div128)
	);

	// Zero-wait slave; unmapped addresses answer with an error and no effect
	assign pready = 1'b1;
	assign hit_valid = is_mapped(paddr) && (paddr[1:0] == 2'h0);
	assign pslverr = psel && penable && !hit_valid;
	assign apb_wr = psel && penable && pwrite && hit_valid;
	assign apb_rd = psel && penable && !pwrite && hit_valid;
	assign wdata16 = pwdata[15:0];
	assign wr_cnt = apb_wr && (paddr == `TCSI_OFF_COUNTER);
	assign wr_status = apb_wr && (paddr == `TCSI_OFF_STATUS) && pstrb[0];
	assign rd_status = apb_rd && (paddr == `TCSI_OFF_STATUS);

	// Capture source: divided slow oscillator, or the external pin when selected
	assign cap_in = io_ctrl0_reg[`TCSI_BIT_CAP_SEL] ? pin_sync2_reg : slow_osc_div128;
	assign cap_event = io_ctrl0_reg[`TCSI_BIT_CAP_MODE] &&
		(io_ctrl0_reg[1:0] == `TCSI_EDGE_RISING) && cap_in && !cap_in_prev_reg;
	// A software load of the counter replaces the step, so no wrap happens then
	assign wrap_event = count_run_reg && !wr_cnt && (timer_counter_reg == 16'hffff);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
			cap_in_prev_reg <= 1'b0;
		end else begin
			pin_sync1_reg <= capture_pin;
			pin_sync2_reg <= pin_sync1_reg;
			cap_in_prev_reg <= cap_in;
		end
	end

	// Counter; a software write wins over counting in that same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_counter_reg <= `TCSI_RST_WORD;
		end else if (wr_cnt) begin
			timer_counter_reg <= merge16(timer_counter_reg, wdata16, pstrb[1:0]);
		end else if (count_run_reg) begin
			timer_counter_reg <= timer_counter_reg + 16'h0001;
		end
	end

	// Capture and buffer registers; a capture wins over a software write in that cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_value_a_reg <= `TCSI_RST_WORD;
			capture_buffer_c_reg <= `TCSI_RST_WORD;
		end else if (cap_event) begin
			capture_value_a_reg <= timer_counter_reg;
			if (io_ctrl1_reg[`TCSI_BIT_C_FUNC]) begin
				capture_buffer_c_reg <= capture_value_a_reg;
			end
		end else if (apb_wr) begin
			if (paddr == `TCSI_OFF_CAP_A) begin
				capture_value_a_reg <= merge16(capture_value_a_reg, wdata16, pstrb[1:0]);
			end
			if (paddr == `TCSI_OFF_BUF_C) begin
				capture_buffer_c_reg <= merge16(capture_buffer_c_reg, wdata16, pstrb[1:0]);
			end
		end
	end

	// Flags: clear needs a prior read as 1; a new event in the clear cycle keeps the flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_flag_a_reg <= 1'b0;
			counter_wrap_flag_reg <= 1'b0;
			cap_seen_reg <= 1'b0;
			wrap_seen_reg <= 1'b0;
		end else begin
			// Remember what software was shown, not a flag that rose after the setup cycle
			if (rd_status) begin
				cap_seen_reg <= prdata[`TCSI_BIT_CAP_FLAG];
				wrap_seen_reg <= prdata[`TCSI_BIT_WRAP_FLAG];
			end
			if (cap_event) begin
				capture_flag_a_reg <= 1'b1;
			end else if (wr_status && !pwdata[`TCSI_BIT_CAP_FLAG] && cap_seen_reg) begin
				capture_flag_a_reg <= 1'b0;
				cap_seen_reg <= 1'b0;
			end
			if (wrap_event) begin
				counter_wrap_flag_reg <= 1'b1;
			end else if (wr_status && !pwdata[`TCSI_BIT_WRAP_FLAG] && wrap_seen_reg) begin
				counter_wrap_flag_reg <= 1'b0;
				wrap_seen_reg <= 1'b0;
			end
		end
	end

	// Control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_irq_en_a_reg <= 1'b0;
			wrap_irq_en_reg <= 1'b0;
			count_run_reg <= 1'b0;
			irq_level_reg <= 3'h0;
			io_ctrl0_reg <= 4'h0;
			io_ctrl1_reg <= 4'h0;
		end else if (apb_wr && pstrb[0]) begin
			case (paddr)
			`TCSI_OFF_IRQ_EN: begin
				capture_irq_en_a_reg <= pwdata[`TCSI_BIT_CAP_IRQ_EN];
				wrap_irq_en_reg <= pwdata[`TCSI_BIT_WRAP_IRQ_EN];
			end
			`TCSI_OFF_MODE: begin
				count_run_reg <= pwdata[`TCSI_BIT_COUNT_RUN];
			end
			`TCSI_OFF_PRIO: begin
				irq_level_reg <= pwdata[2:0];
			end
			`TCSI_OFF_IO_CTRL0: begin
				io_ctrl0_reg <= pwdata[3:0];
			end
			`TCSI_OFF_IO_CTRL1: begin
				io_ctrl1_reg <= pwdata[3:0];
			end
			default: begin
				count_run_reg <= count_run_reg;
			end
			endcase
		end
	end

	// Interrupt sources, gated by enables; level 0 disables the timer interrupt
	assign capture_irq_a = capture_flag_a_reg && capture_irq_en_a_reg;
	assign wrap_irq = counter_wrap_flag_reg && wrap_irq_en_reg;
	assign irq_request_pending = capture_irq_a || wrap_irq;
	assign irq = irq_request_pending && (irq_level_reg != 3'h0);

	always @* begin
		rdata_next = 32'h0000_0000;
		case (paddr)
		`TCSI_OFF_STATUS: begin
			rdata_next[`TCSI_BIT_CAP_FLAG] = capture_flag_a_reg;
			rdata_next[`TCSI_BIT_WRAP_FLAG] = counter_wrap_flag_reg;
		end
		`TCSI_OFF_IRQ_EN: begin
			rdata_next[7:0] = {wrap_irq_en_reg, 6'h00, capture_irq_en_a_reg};
		end
		`TCSI_OFF_MODE: begin
			rdata_next[7:0] = {count_run_reg, 7'h00};
		end
		`TCSI_OFF_PRIO: begin
			rdata_next[2:0] = irq_level_reg;
			rdata_next[`TCSI_BIT_IRQ_PENDING] = irq_request_pending;
		end
		`TCSI_OFF_CAP_A: begin
			rdata_next[15:0] = capture_value_a_reg;
		end
		`TCSI_OFF_BUF_C: begin
			rdata_next[15:0] = capture_buffer_c_reg;
		end
		`TCSI_OFF_IO_CTRL0: begin
			rdata_next[3:0] = io_ctrl0_reg;
		end
		`TCSI_OFF_IO_CTRL1: begin
			rdata_next[3:0] = io_ctrl1_reg;
		end
		`TCSI_OFF_COUNTER: begin
			rdata_next[15:0] = timer_counter_reg;
		end
		default: begin
			rdata_next = 32'h0000_0000;
		end
		endcase
	end

	// Read data registered during setup so it is stable through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata_next;
		end
	end
endmodule

// file: verification/tcsi_timer_checker.sv
// Port-level assertions for the capture timer
`timescale 1ns/1ps
module tcsi_timer_checker (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	input wire irq,
	input wire capture_irq_a,
	input wire wrap_irq
);
	wire acc = psel && penable;
	// Only a status or enable write may lower a flag request
	wire wst = acc && pwrite && (paddr == 12'h000 || paddr == 12'h004);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_wrap_req_sticky: assert property (wrap_irq && !wst |=> wrap_irq)
		else $error("wrap request dropped without a write");
	a_cap_req_sticky: assert property (capture_irq_a && !wst |=> capture_irq_a)
		else $error("capture request dropped without a write");
	a_irq_has_source: assert property (irq |-> capture_irq_a || wrap_irq)
		else $error("irq high with no source");
	a_unmapped_err: assert property (acc && paddr > 12'h020 |-> pslverr)
		else $error("no error on unmapped access");
	a_mapped_no_err: assert property (acc && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped access");
	a_err_reads_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h00000000)
		else $error("refused read returned data");
	a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read setup");
	a_zero_wait: assert property (acc |-> pready)
		else $error("access phase stalled");
endmodule
bind tcsi_timer tcsi_timer_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .irq(irq), .capture_irq_a(capture_irq_a), .wrap_irq(wrap_irq));

// file: verification/tb_timer_capture_status_irq.sv
// Self-checking bench for the capture timer
`timescale 1ns/1ps
module tb_timer_capture_status_irq;
	logic pclk, presetn, psel, penable, pwrite, osc, osc_en, ph, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, q, a1;
	wire pready, pslverr, irq, cap_irq, wrap_irq;
	wire [31:0] prdata;
	int bad_count, num_checks, i;
	logic [11:0] ra[8] = '{12'h004, 12'h00c, 12'h018, 12'h01c, 12'h010, 12'h014, 12'h020, 12'h024};
	logic [31:0] rw[8] = '{32'h00000081, 32'h00000001, 32'h00000004, 32'h00000008,
		32'h00001234, 32'h0000beef, 32'h000000ab, 32'h0000005a};
	tcsi_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .slow_internal_osc(osc), .capture_pin(1'b0),
		.irq(irq), .capture_irq_a(cap_irq), .wrap_irq(wrap_irq));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Oscillator period of exactly 4 pclk keeps the capture spacing predictable
	always @(posedge pclk) begin
		ph <= ~ph;
		if (osc_en && ph) osc <= ~osc;
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wait_cap;
		int n;
		for (n = 0; n < 2000 && cap_irq !== 1'b1; n++) @(posedge pclk);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (8000) @(posedge pclk);
		bad_count++;
		conclude;
	end
	initial begin
		{presetn, psel, penable, pwrite, osc, osc_en, ph} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 9; i++) begin
			apb(1'b0, 12'(i * 4), 32'h00000000);
			chk("reset value", 32'h00000000, q);
		end
		$display("reset test done");
		for (i = 0; i < 8; i++) begin
			apb(1'b1, ra[i], rw[i]);
			apb(1'b0, ra[i], 32'h00000000);
			chk("readback", (i == 7) ? 32'h00000000 : rw[i], q);
			chk("slverr", 32'(i == 7), 32'(e));
		end
		$display("register table test done");
		apb(1'b1, 12'h020, 32'h0000fffd);
		apb(1'b1, 12'h008, 32'h00000080);
		for (i = 0; i < 20 && wrap_irq !== 1'b1; i++) @(posedge pclk);
		apb(1'b1, 12'h008, 32'h00000000);
		chk("wrap irq", 32'h1, 32'(wrap_irq));
		chk("irq", 32'h1, 32'(irq));
		apb(1'b0, 12'h00c, 32'h00000000);
		chk("pending bit", 32'h1, 32'(q[3]));
		apb(1'b1, 12'h00c, 32'h00000000);
		chk("irq at level 0", 32'h0, 32'(irq));
		apb(1'b1, 12'h00c, 32'h00000001);
		apb(1'b1, 12'h000, 32'h00000000);
		apb(1'b0, 12'h000, 32'h00000000);
		chk("clear without read", 32'h1, 32'(q[7]));
		apb(1'b1, 12'h000, 32'h00000000);
		apb(1'b0, 12'h000, 32'h00000000);
		chk("clear after read", 32'h0, 32'(q[7]));
		chk("irq cleared", 32'h0, 32'(irq));
		$display("wrap flag test done");
		osc_en <= 1'b1;
		apb(1'b1, 12'h008, 32'h00000080);
		wait_cap;
		chk("capture irq", 32'h1, 32'(irq));
		apb(1'b0, 12'h010, 32'h00000000);
		a1 = q;
		apb(1'b0, 12'h014, 32'h00000000);
		chk("first buffer", 32'h00001234, q);
		apb(1'b0, 12'h000, 32'h00000000);
		chk("capture flag", 32'h1, 32'(q[0]));
		apb(1'b1, 12'h000, 32'h00000000);
		wait_cap;
		apb(1'b0, 12'h014, 32'h00000000);
		chk("buffer holds old A", a1, q);
		apb(1'b0, 12'h010, 32'h00000000);
		chk("capture spacing", 32'h00000200, (q - a1) & 32'h0000ffff);
		$display("capture test done");
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("irq after reset", 32'h0, 32'(irq));
		apb(1'b0, 12'h000, 32'h00000000);
		chk("status after reset", 32'h00000000, q);
		apb(1'b0, 12'h010, 32'h00000000);
		chk("A after reset", 32'h00000000, q);
		$display("mid-run reset test done");
		conclude;
	end
endmodule
